// ---- design/bls_device.sv ----
// backlight controller serial port: slave side of the two-wire link
// assumes a free-running link clock well above the bus rate, and a host
// that does not stretch or arbitrate

// Behaviour
// - write is address, command, data; data stored
// - read is address, command, restart, address, data
// - read returns register chosen by prior command
// - device drives data only on acks, read data
// - address upper nibble must be 0101
// - address bit three must be one
// - address byte 0x58 write, 0x59 read
// - direction bit high reads, low writes
// - leds stay off until host enables them or both lines are low at power-up
// - both lines low at power-up: leds on
// - unused bus fixes switching frequency low
// - byte registers; reserved bits read zero, except config bit 1, which reads one until the first write
module bls_device import bls_pkg::*; #(
  parameter logic [7:0] IDENT_VALUE = 8'ha5, // arbitrary value
  parameter int REG_COUNT = BLS_REG_COUNT
) (
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  bls_link_if.device link,
  output logic led_on_o,
  output logic fsw_low_o,
  output logic autonomous_o,
  output logic [7:0] pwm_bright_o,
  output logic [7:0] dc_bright_o,
  output logic [5:0] chan_en_o
);

  localparam int IDX_W = $clog2(REG_COUNT);

  // ==========================================================================
  // pin sampling
  logic scl_s;
  logic sda_s;
  logic scl_d;
  logic sda_d;

  bls_sync #(
    .STAGES(BLS_PIN_STAGES),
    .RESET_VAL(1'b1)
  ) u_scl_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(link.scl),
    .q_o(scl_s)
  );

  bls_sync #(
    .STAGES(BLS_PIN_STAGES),
    .RESET_VAL(1'b1)
  ) u_sda_sync (
    .clk_i(link_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(link.sda),
    .q_o(sda_s)
  );

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_d <= 1'b1;
      sda_d <= 1'b1;
    end else begin
      scl_d <= scl_s;
      sda_d <= sda_s;
    end
  end

  wire scl_rise = scl_s & ~scl_d;
  wire scl_fall = ~scl_s & scl_d;
  wire start_cond = scl_s & scl_d & sda_d & ~sda_s;
  wire stop_cond = scl_s & scl_d & ~sda_d & sda_s;

  // ==========================================================================
  // state
  bls_dev_state_t state;
  bls_dev_state_t next_state;
  bls_dev_state_t after;
  bls_dev_state_t next_after;
  logic [3:0] bitcnt;
  logic [3:0] next_bitcnt;
  logic [7:0] shreg;
  logic [7:0] next_shreg;
  logic [7:0] index;
  logic [7:0] next_index;
  logic drive_low;
  logic next_drive_low;
  logic [7:0] regs [REG_COUNT];
  logic [7:0] rd_value;
  logic [7:0] status_value;

  // ==========================================================================
  // decode
  wire byte_done = scl_fall && (bitcnt == BLS_BYTE_BITS);
  wire class_ok = shreg[7:BLS_CLASS_LSB] == BLS_CLASS;
  wire bit3_ok = shreg[BLS_ADDR_BIT3];
  wire full_ok = shreg[7:1] == BLS_ADDR_W[7:1];
  wire addr_match = class_ok & bit3_ok & full_ok;
  wire dir_read = shreg[0] == BLS_DIR_READ;
  wire idx_ok = index < REG_COUNT;
  wire wr_stb = (state == ST_DATA) && byte_done;

  assign status_value = led_on_o ? BLS_STATUS_LED : BLS_RST_ZERO;
  // unmapped indices and reserved bits come back as zero, except config bit 1, which resets to one and clears on the first write
  assign rd_value = (index == BLS_IDX_STATUS) ? status_value :
                    (index == BLS_IDX_IDENT) ? IDENT_VALUE :
                    idx_ok ? regs[index[IDX_W-1:0]] : BLS_RST_ZERO;

  // ==========================================================================
  // byte sequencer
  always_comb begin
    next_state = state;
    next_after = after;
    next_bitcnt = bitcnt;
    next_shreg = shreg;
    next_index = index;
    next_drive_low = drive_low;
    if (stop_cond) begin
      next_state = ST_IDLE;
      next_drive_low = 1'b0;
    end else if (start_cond) begin
      // a repeated start keeps the command index for the read
      next_state = ST_ADDR;
      next_bitcnt = '0;
      next_drive_low = 1'b0;
    end else begin
      case (state)
        ST_ADDR, ST_CMD, ST_DATA: begin
          if (scl_rise && bitcnt != BLS_BYTE_BITS) begin
            next_shreg = {shreg[6:0], sda_s};
            next_bitcnt = bitcnt + 4'h1;
          end else if (byte_done) begin
            next_bitcnt = '0;
            if (state == ST_ADDR) begin
              if (addr_match) begin
                next_drive_low = 1'b1;
                next_state = ST_ACK;
                next_after = dir_read ? ST_READ : ST_CMD;
              end else begin
                next_state = ST_SKIP;
              end
            end else if (state == ST_CMD) begin
              next_index = shreg;
              next_drive_low = 1'b1;
              next_state = ST_ACK;
              next_after = ST_DATA;
            end else begin
              // a fourth byte in a write is not acknowledged
              next_drive_low = 1'b1;
              next_state = ST_ACK;
              next_after = ST_SKIP;
            end
          end
        end
        ST_ACK: begin
          if (scl_fall) begin
            next_state = after;
            next_drive_low = 1'b0;
            next_bitcnt = '0;
            if (after == ST_READ) begin
              next_shreg = rd_value;
              next_drive_low = ~rd_value[7];
            end
          end
        end
        ST_READ: begin
          if (scl_fall) begin
            if (bitcnt == BLS_LAST_BIT) begin
              // host owns the ack slot of the returned byte
              next_drive_low = 1'b0;
              next_state = ST_SKIP;
            end else begin
              next_shreg = {shreg[6:0], 1'b0};
              next_drive_low = ~shreg[6];
              next_bitcnt = bitcnt + 4'h1;
            end
          end
        end
        default: begin
          next_drive_low = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= ST_IDLE;
      after <= ST_IDLE;
      bitcnt <= '0;
      shreg <= '0;
      index <= '0;
      drive_low <= 1'b0;
    end else begin
      state <= next_state;
      after <= next_after;
      bitcnt <= next_bitcnt;
      shreg <= next_shreg;
      index <= next_index;
      drive_low <= next_drive_low;
    end
  end

  // open drain: only ever pull low
  assign link.dev_sda_o = 1'b0;
  assign link.dev_sda_oe_n = ~drive_low;

  // ==========================================================================
  // register file
  generate
    for (genvar i = 0; i < REG_COUNT; i++) begin : g_reg
      localparam logic [7:0] IDX = 8'(i);
      always_ff @(posedge link_clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          regs[i] <= bls_rstval(IDX);
        end else if (wr_stb && index == IDX) begin
          regs[i] <= shreg & bls_wmask(IDX);
        end
      end
    end
  endgenerate

  // ==========================================================================
  // power-up strap and outputs
  logic [3:0] strap_cnt;
  logic strap_done;
  logic ctrl_on;
  logic cfg_low;

  assign ctrl_on = regs[BLS_IDX_CTRL[IDX_W-1:0]][BLS_CTRL_LED_BIT];
  assign cfg_low = regs[BLS_IDX_CONFIG[IDX_W-1:0]][BLS_CONFIG_FSW_BIT];

  // wait for the pin chains to fill before trusting the lines
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      strap_cnt <= '0;
      strap_done <= 1'b0;
      autonomous_o <= 1'b0;
    end else if (!strap_done) begin
      if (strap_cnt == BLS_STRAP_WAIT) begin
        strap_done <= 1'b1;
        autonomous_o <= ~scl_s & ~sda_s;
      end else begin
        strap_cnt <= strap_cnt + 4'h1;
      end
    end
  end

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      led_on_o <= 1'b0;
      fsw_low_o <= 1'b1;
      pwm_bright_o <= BLS_RST_BRIGHT;
      dc_bright_o <= BLS_RST_BRIGHT;
      chan_en_o <= BLS_RST_CHAN[5:0];
    end else begin
      led_on_o <= strap_done & (autonomous_o | ctrl_on);
      fsw_low_o <= autonomous_o | cfg_low;
      pwm_bright_o <= regs[BLS_IDX_BRIGHT[IDX_W-1:0]];
      dc_bright_o <= regs[BLS_IDX_DCBRIGHT[IDX_W-1:0]];
      chan_en_o <= regs[BLS_IDX_CHAN[IDX_W-1:0]][5:0];
    end
  end

endmodule : bls_device

// ---- design/bls_host.sv ----
// host master for the backlight port: one write byte or read byte per request
// assumes the slave never stretches the clock; no arbitration

module bls_host import bls_pkg::*; #(
  parameter int QUARTER = BLS_QUARTER_CYCLES
) (
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  bls_link_if.host link,
  input wire logic req_i,
  input wire logic read_i,
  input wire logic [7:0] cmd_i,
  input wire logic [7:0] wdata_i,
  output logic ready_o,
  output logic done_o,
  output logic nack_o,
  output logic [7:0] rdata_o
);

  // ==========================================================================
  // state
  bls_host_state_t state;
  logic [15:0] qcnt;
  logic [1:0] phase;
  logic [2:0] byte_no;
  logic [3:0] bit_no;
  logic rd;
  logic [7:0] cmd;
  logic [7:0] wdata;
  logic [7:0] rx;
  logic scl_low;
  logic sda_low;
  logic sda_s;

  bls_sync #(
    .STAGES(BLS_PIN_STAGES),
    .RESET_VAL(1'b1)
  ) u_sda_sync (
    .clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .d_i(link.sda),
    .q_o(sda_s)
  );

  // ==========================================================================
  // decode
  wire tick = qcnt == 16'(QUARTER - 1);
  wire rx_byte = byte_no == 3'h4;
  wire [7:0] tx_byte = (byte_no == 3'h0) ? BLS_ADDR_W :
                       (byte_no == 3'h1) ? cmd :
                       (byte_no == 3'h2) ? wdata :
                       (byte_no == 3'h3) ? BLS_ADDR_R : BLS_MASK_FULL;
  wire data_bit = bit_no != BLS_BYTE_BITS;
  wire tx_bit = tx_byte[3'(BLS_LAST_BIT[2:0] - bit_no[2:0])];

  assign ready_o = state == H_IDLE;
  assign link.host_scl_o = 1'b0;
  assign link.host_scl_oe_n = ~scl_low;
  assign link.host_sda_o = 1'b0;
  assign link.host_sda_oe_n = ~sda_low;

  // ==========================================================================
  // quarter-bit sequencer
  always_ff @(posedge ref_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state <= H_IDLE;
      qcnt <= '0;
      phase <= '0;
      byte_no <= '0;
      bit_no <= '0;
      rd <= 1'b0;
      cmd <= '0;
      wdata <= '0;
      rx <= '0;
      scl_low <= 1'b0;
      sda_low <= 1'b0;
      done_o <= 1'b0;
      nack_o <= 1'b0;
      rdata_o <= '0;
    end else begin
      done_o <= 1'b0;
      qcnt <= (state == H_IDLE || tick) ? '0 : qcnt + 16'h1;
      if (state == H_IDLE) begin
        phase <= '0;
        if (req_i) begin
          state <= H_START;
          rd <= read_i;
          cmd <= cmd_i;
          wdata <= wdata_i;
          byte_no <= '0;
          nack_o <= 1'b0;
        end
      end else if (tick) begin
        phase <= phase + 2'h1;
        case (state)
          H_START: begin
            // also serves as repeated start from a low clock
            // sda never moves on the same edge as scl: keeps hold time
            if (phase == 2'h0) begin
              scl_low <= 1'b1;
            end else if (phase == 2'h1) begin
              sda_low <= 1'b0;
            end else if (phase == 2'h2) begin
              scl_low <= 1'b0;
            end else begin
              sda_low <= 1'b1;
              state <= H_BIT;
              bit_no <= '0;
            end
          end
          H_BIT: begin
            if (phase == 2'h0) begin
              scl_low <= 1'b1;
            end else if (phase == 2'h1) begin
              // released on slave-owned slots and on the final nack
              sda_low <= data_bit & ~rx_byte & ~tx_bit;
            end else if (phase == 2'h2) begin
              scl_low <= 1'b0;
            end else if (phase == 2'h3) begin
              if (data_bit) begin
                rx <= {rx[6:0], sda_s};
                bit_no <= bit_no + 4'h1;
              end else if (!rx_byte && sda_s) begin
                nack_o <= 1'b1;
                state <= H_STOP;
              end else if (byte_no == 3'h1 && rd) begin
                byte_no <= 3'h3;
                state <= H_START;
              end else if (byte_no == 3'h2 || rx_byte) begin
                state <= H_STOP;
                if (rx_byte) begin
                  rdata_o <= rx;
                end
              end else begin
                byte_no <= byte_no + 3'h1;
                bit_no <= '0;
              end
            end
          end
          H_STOP: begin
            if (phase == 2'h0) begin
              scl_low <= 1'b1;
            end else if (phase == 2'h1) begin
              sda_low <= 1'b1;
            end else if (phase == 2'h2) begin
              scl_low <= 1'b0;
            end else if (phase == 2'h3) begin
              sda_low <= 1'b0;
              done_o <= 1'b1;
              state <= H_IDLE;
            end
          end
          default: begin
            state <= H_IDLE;
          end
        endcase
      end
    end
  end

endmodule : bls_host

// ---- design/bls_link_if.sv ----
// two-wire link between host and backlight port
// assumes external pull-ups: a released line reads high

interface bls_link_if;

  // ==========================================================================
  // drivers and resolved wires
  logic host_scl_o;
  logic host_scl_oe_n;
  logic host_sda_o;
  logic host_sda_oe_n;
  logic dev_sda_o;
  logic dev_sda_oe_n;
  logic scl;
  logic sda;

  // wired-and of open-drain drivers
  assign scl = host_scl_oe_n | host_scl_o;
  assign sda = (host_sda_oe_n | host_sda_o) & (dev_sda_oe_n | dev_sda_o);

  modport host (
    output host_scl_o,
    output host_scl_oe_n,
    output host_sda_o,
    output host_sda_oe_n,
    input scl,
    input sda
  );

  modport device (
    output dev_sda_o,
    output dev_sda_oe_n,
    input scl,
    input sda
  );

endinterface : bls_link_if

// ---- design/bls_pkg.sv ----
// shared constants and types for the backlight smbus slave port and its host
// assumes a 20 mhz reference clock on the host side and a free link clock on the device

package bls_pkg;

  // ==========================================================================
  // address byte
  localparam logic [3:0] BLS_CLASS = 4'h5;
  localparam int BLS_CLASS_LSB = 4;
  localparam int BLS_ADDR_BIT3 = 3;
  localparam logic [7:0] BLS_ADDR_W = 8'h58;
  localparam logic [7:0] BLS_ADDR_R = 8'h59;
  localparam logic BLS_DIR_READ = 1'b1;
  localparam logic [3:0] BLS_BYTE_BITS = 4'h8;
  localparam logic [3:0] BLS_LAST_BIT = 4'h7;

  // ==========================================================================
  // register indices, write masks and reset values
  localparam int BLS_REG_COUNT = 16;
  localparam logic [7:0] BLS_IDX_BRIGHT = 8'h00;
  localparam logic [7:0] BLS_IDX_CTRL = 8'h01;
  localparam logic [7:0] BLS_IDX_STATUS = 8'h02;
  localparam logic [7:0] BLS_IDX_IDENT = 8'h03;
  localparam logic [7:0] BLS_IDX_DCBRIGHT = 8'h07;
  localparam logic [7:0] BLS_IDX_CONFIG = 8'h08;
  localparam logic [7:0] BLS_IDX_CHAN = 8'h09;
  localparam logic [7:0] BLS_IDX_PHASE = 8'h0a;
  localparam logic [7:0] BLS_MASK_CTRL = 8'h07;
  localparam logic [7:0] BLS_MASK_CONFIG = 8'h1d;
  localparam logic [7:0] BLS_MASK_CHAN = 8'h3f;
  localparam logic [7:0] BLS_MASK_FULL = 8'hff;
  localparam logic [7:0] BLS_RST_BRIGHT = 8'hff;
  localparam logic [7:0] BLS_RST_CONFIG = 8'h1f;
  localparam logic [7:0] BLS_RST_CHAN = 8'h3f;
  localparam logic [7:0] BLS_RST_ZERO = 8'h00;
  localparam int BLS_CTRL_LED_BIT = 0;
  localparam int BLS_CONFIG_FSW_BIT = 2;
  localparam logic [7:0] BLS_STATUS_LED = 8'h08;

  // ==========================================================================
  // timing
  localparam int BLS_PIN_STAGES = 3;
  localparam int BLS_XING_STAGES = 2;
  localparam logic [3:0] BLS_STRAP_WAIT = 4'h4;
  localparam int BLS_REF_HZ = 20_000_000;
  localparam int BLS_SCL_HZ = 100_000;
  localparam int BLS_QUARTER_CYCLES = BLS_REF_HZ / (BLS_SCL_HZ * 4);

  typedef enum {
    ST_IDLE, ST_ADDR, ST_CMD, ST_DATA, ST_ACK, ST_READ, ST_SKIP
  } bls_dev_state_t;

  typedef enum {
    H_IDLE, H_START, H_BIT, H_STOP
  } bls_host_state_t;

  function automatic logic [7:0] bls_wmask(input logic [7:0] idx);
    if (idx == BLS_IDX_CTRL) return BLS_MASK_CTRL;
    else if (idx == BLS_IDX_CONFIG) return BLS_MASK_CONFIG;
    else if (idx == BLS_IDX_CHAN) return BLS_MASK_CHAN;
    else if (idx == BLS_IDX_BRIGHT || idx == BLS_IDX_DCBRIGHT || idx == BLS_IDX_PHASE) return BLS_MASK_FULL;
    else return BLS_RST_ZERO;
  endfunction : bls_wmask

  function automatic logic [7:0] bls_rstval(input logic [7:0] idx);
    if (idx == BLS_IDX_BRIGHT || idx == BLS_IDX_DCBRIGHT) return BLS_RST_BRIGHT;
    else if (idx == BLS_IDX_CONFIG) return BLS_RST_CONFIG;
    else if (idx == BLS_IDX_CHAN) return BLS_RST_CHAN;
    else return BLS_RST_ZERO;
  endfunction : bls_rstval

endpackage : bls_pkg

// ---- design/bls_sync.sv ----
// flip-flop chain for a level from another clock domain
// assumes STAGES >= 2; output follows once the last two stages agree

module bls_sync #(
  parameter int STAGES = 3,
  parameter logic RESET_VAL = 1'b1
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic d_i,
  output logic q_o
);

  // ==========================================================================
  // chain
  logic [STAGES-1:0] chain;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      chain <= {STAGES{RESET_VAL}};
      q_o <= RESET_VAL;
    end else begin
      chain <= {chain[STAGES-2:0], d_i};
      // first stage feeds only the second
      if (chain[STAGES-1] == chain[STAGES-2]) begin
        q_o <= chain[STAGES-1];
      end
    end
  end

endmodule : bls_sync

// ---- verif/bls_link_checker.sv ----
// concurrent checks on the two-wire link between the host and device ends
// assumes the resolved wires and drivers of the link interface, one shared reset
module bls_link_checker (
  input wire logic ref_clk_i,
  input wire logic link_clk_i,
  input wire logic rst_n_i,
  input wire logic host_scl_o,
  input wire logic host_sda_o,
  input wire logic host_sda_oe_n,
  input wire logic dev_sda_o,
  input wire logic dev_sda_oe_n,
  input wire logic scl,
  input wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;

  // ====================
  // byte tracker on the link clock; raw wires, no sync needed in sim
  logic scl_q;
  logic sda_q;
  logic [3:0] bit_cnt;
  logic [1:0] byte_no;
  logic [7:0] shift;
  logic addr_ok;
  logic rd;
  wire logic scl_rise = scl && !scl_q;
  wire logic start_seen = scl && scl_q && sda_q && !sda;
  wire logic ninth = scl_rise && (bit_cnt == 4'h8);
  wire logic dev_bit = scl_rise && (bit_cnt < 4'h8) && (byte_no == 2'h1) && rd && addr_ok;
  wire logic host_bit = scl_rise && (bit_cnt < 4'h8) && !dev_bit;
  wire logic addr_hit = (shift[7:1] == 7'h2c);

  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end else begin
      scl_q <= scl;
      sda_q <= sda;
    end
  end

  // byte count saturates so trailing bytes never wrap onto the address slot
  always_ff @(posedge link_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt <= 4'h0;
      byte_no <= 2'h0;
      shift <= 8'h00;
      addr_ok <= 1'b0;
      rd <= 1'b0;
    end else if (start_seen) begin
      bit_cnt <= 4'h0;
      byte_no <= 2'h0;
    end else if (ninth) begin
      bit_cnt <= 4'h0;
      byte_no <= (byte_no == 2'h3) ? byte_no : byte_no + 2'h1;
      addr_ok <= (byte_no == 2'h0) ? addr_hit : addr_ok;
      rd <= (byte_no == 2'h0) ? shift[0] : rd;
    end else if (scl_rise) begin
      bit_cnt <= bit_cnt + 4'h1;
      shift <= {shift[6:0], sda};
    end
  end

  // ====================
  // assertions
  chk_addr_ack: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    (ninth && byte_no == 2'h0) |-> (sda == !addr_hit)) else $error("address ack wrong");
  chk_cmd_ack: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    (ninth && byte_no == 2'h1 && addr_ok && !rd) |-> !sda) else $error("command byte not acked");
  chk_data_ack: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    (ninth && byte_no == 2'h2 && addr_ok && !rd) |-> !sda) else $error("write data not acked");
  chk_read_nack: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    (ninth && byte_no == 2'h1 && addr_ok && rd) |-> sda) else $error("read byte not ended by host");
  chk_host_yields: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    dev_bit |-> host_sda_oe_n) else $error("host drives during read data");
  chk_dev_quiet: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    host_bit |-> dev_sda_oe_n) else $error("device drives a host bit");
  chk_dev_take_low: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $fell(dev_sda_oe_n) |-> !scl) else $error("device took data line with clock high");
  chk_dev_let_go: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $rose(dev_sda_oe_n) |-> !scl) else $error("device released data line with clock high");
  chk_dev_drive_end: assert property (@(posedge link_clk_i) disable iff (!rst_n_i)
    $fell(dev_sda_oe_n) |-> ##[1:400] dev_sda_oe_n) else $error("device holds data line too long");
  chk_open_drain: assert property (@(posedge ref_clk_i) disable iff (!rst_n_i)
    !host_sda_oe_n |-> (!host_sda_o && !host_scl_o && !dev_sda_o)) else $error("line driven high");

endmodule : bls_link_checker

// ---- verif/tb_backlight_smbus_slave_port.sv ----
// bench: host and device ends joined on one link; a second device on a
// bench-driven link covers address faults and the grounded-bus strap
// assumes bls_pkg, bls_link_if and the design modules compiled first
module tb_backlight_smbus_slave_port;
  timeunit 1ns;
  timeprecision 1ps;

  // ====================
  // signals and tables
  logic ref_clk_i, link_clk_i, rst_n_i;
  logic req, read, ready, done, nack;
  logic [7:0] cmd, wdata, rdata, pwm, dcb, rv;
  logic led_on, fsw_low, auto_on, led_on_b, fsw_low_b, auto_on_b, ack;
  logic [5:0] chan, chan_b;
  int fails, samples_checked, cyc, wbits, i;
  logic [7:0] wsh;
  logic [8:0] wire_q[$];
  logic [7:0] idx [9] = '{8'h00, 8'h01, 8'h08, 8'h09, 8'h0a, 8'h07, 8'h03, 8'h02, 8'h0f};
  logic [7:0] rst_v [9] = '{8'hff, 8'h00, 8'h1f, 8'h3f, 8'h00, 8'hff, 8'ha5, 8'h00, 8'h00};
  logic [7:0] wr_v [9] = '{8'h3c, 8'hff, 8'hff, 8'hff, 8'h5a, 8'hc3, 8'h00, 8'hff, 8'h77};
  logic [7:0] exp_v [9] = '{8'h3c, 8'h07, 8'h1d, 8'h3f, 8'h5a, 8'hc3, 8'ha5, 8'h08, 8'h00};
  logic [7:0] adr [4] = '{8'h50, 8'hd8, 8'h48, 8'h58};
  logic adr_ack [4] = '{1'b1, 1'b1, 1'b1, 1'b0};

  bls_link_if link_a();
  bls_link_if link_b();

  bls_host #(.QUARTER(8)) i_bls_host (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i), .link(link_a),
    .req_i(req), .read_i(read), .cmd_i(cmd), .wdata_i(wdata), .ready_o(ready), .done_o(done),
    .nack_o(nack), .rdata_o(rdata));
  // ident value arbitrary
  bls_device #(.IDENT_VALUE(8'ha5)) i_bls_device (.link_clk_i(link_clk_i), .rst_n_i(rst_n_i),
    .link(link_a), .led_on_o(led_on), .fsw_low_o(fsw_low), .autonomous_o(auto_on),
    .pwm_bright_o(pwm), .dc_bright_o(dcb), .chan_en_o(chan));
  bls_device #(.IDENT_VALUE(8'ha5)) i_bls_device_2 (.link_clk_i(link_clk_i), .rst_n_i(rst_n_i),
    .link(link_b), .led_on_o(led_on_b), .fsw_low_o(fsw_low_b), .autonomous_o(auto_on_b),
    .pwm_bright_o(), .dc_bright_o(), .chan_en_o(chan_b));
  bls_link_checker i_bls_link_checker (.ref_clk_i(ref_clk_i), .link_clk_i(link_clk_i),
    .rst_n_i(rst_n_i), .host_scl_o(link_a.host_scl_o), .host_sda_o(link_a.host_sda_o),
    .host_sda_oe_n(link_a.host_sda_oe_n), .dev_sda_o(link_a.dev_sda_o),
    .dev_sda_oe_n(link_a.dev_sda_oe_n), .scl(link_a.scl), .sda(link_a.sda));

  // ====================
  // clocks, timeout, wire monitor
  initial begin
    ref_clk_i = 1'b0;
    forever #25 ref_clk_i = ~ref_clk_i;
  end
  initial begin
    link_clk_i = 1'b0;
    #7.3;
    forever #24 link_clk_i = ~link_clk_i;
  end
  always @(posedge ref_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      fails++;
      summarize();
    end
  end
  // byte plus ack level seen on the wire, msb first
  always @(negedge link_a.sda) if (link_a.scl === 1'b1) wbits = 0;
  always @(posedge link_a.scl) begin
    if (wbits == 8) wire_q.push_back({wsh, link_a.sda});
    else wsh = {wsh[6:0], link_a.sda};
    wbits = (wbits == 8) ? 0 : wbits + 1;
  end

  // ====================
  // tasks
  task automatic cmp(input logic [31:0] seen, input logic [31:0] expv);
    samples_checked++;
    if (seen !== expv) begin
      fails++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, expv);
    end
  endtask : cmp

  task automatic summarize();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : summarize

  task automatic xfer(input logic rd, input logic [7:0] c, input logic [7:0] wd, output logic [7:0] rdv);
    int n;
    wire_q.delete();
    req <= 1'b1;
    read <= rd;
    cmd <= c;
    wdata <= wd;
    @(posedge ref_clk_i);
    req <= 1'b0;
    n = 0;
    while (done !== 1'b1 && n < 5000) begin
      @(negedge ref_clk_i);
      n++;
    end
    cmp(n < 5000, 1'b1);
    cmp(ready, 1'b1);
    rdv = rdata;
    cmp(nack, 1'b0);
    cmp(wire_q.size(), rd ? 4 : 3);
    cmp(wire_q[0], {8'h58, 1'b0});
    cmp(wire_q[1], {c, 1'b0});
    if (rd) begin
      cmp(wire_q[2], {8'h59, 1'b0});
      cmp(wire_q[3], {rdv, 1'b1});
    end else cmp(wire_q[2], {wd, 1'b0});
    @(posedge ref_clk_i);
  endtask : xfer

  // bench-driven second link; 8 ref cycles per quarter bit
  task automatic quarter();
    repeat (8) @(posedge ref_clk_i);
  endtask : quarter

  task automatic bb_start();
    link_b.host_sda_oe_n <= 1'b0;
    quarter();
    link_b.host_scl_oe_n <= 1'b0;
    quarter();
  endtask : bb_start

  // last bit released so the device may ack it
  task automatic bb_byte(input logic [8:0] bits, output logic ackv);
    for (int k = 8; k >= 0; k--) begin
      link_b.host_sda_oe_n <= bits[k];
      quarter();
      link_b.host_scl_oe_n <= 1'b1;
      quarter();
      if (k == 0) ackv = link_b.sda;
      quarter();
      link_b.host_scl_oe_n <= 1'b0;
      quarter();
    end
  endtask : bb_byte

  task automatic bb_stop();
    link_b.host_sda_oe_n <= 1'b0;
    quarter();
    link_b.host_scl_oe_n <= 1'b1;
    quarter();
    link_b.host_sda_oe_n <= 1'b1;
    quarter();
  endtask : bb_stop

  // ====================
  // main sequence
  initial begin
    rst_n_i = 1'b0;
    req = 1'b0;
    read = 1'b0;
    cmd = 8'h00;
    wdata = 8'h00;
    fails = 0;
    samples_checked = 0;
    cyc = 0;
    wbits = 0;
    link_b.host_scl_o = 1'b0;
    link_b.host_sda_o = 1'b0;
    // second link grounded through power-up
    link_b.host_scl_oe_n = 1'b0;
    link_b.host_sda_oe_n = 1'b0;
    repeat (16) @(posedge ref_clk_i);
    rst_n_i <= 1'b1;
    repeat (40) @(posedge ref_clk_i);
    link_b.host_scl_oe_n <= 1'b1;
    quarter();
    link_b.host_sda_oe_n <= 1'b1;
    quarter();
    cmp(auto_on_b, 1'b1);
    cmp(led_on_b, 1'b1);
    cmp(fsw_low_b, 1'b1);
    cmp(auto_on, 1'b0);
    cmp(led_on, 1'b0);
    for (i = 0; i < 9; i++) begin
      xfer(1'b1, idx[i], 8'h00, rv);
      cmp(rv, rst_v[i]);
    end
    for (i = 0; i < 9; i++) begin
      xfer(1'b0, idx[i], wr_v[i], rv);
      xfer(1'b1, idx[i], 8'h00, rv);
      cmp(rv, exp_v[i]);
    end
    cmp(pwm, 8'h3c);
    cmp(dcb, 8'hc3);
    cmp(led_on, 1'b1);
    cmp(fsw_low, 1'b1);
    xfer(1'b0, 8'h08, 8'h00, rv);
    cmp(fsw_low, 1'b0);
    xfer(1'b0, 8'h09, 8'h15, rv);
    cmp(chan, 6'h15);
    xfer(1'b0, 8'h01, 8'h00, rv);
    cmp(led_on, 1'b0);
    xfer(1'b1, 8'h02, 8'h00, rv);
    cmp(rv, 8'h00);
    for (i = 0; i < 4; i++) begin
      bb_start();
      bb_byte({adr[i], 1'b1}, ack);
      cmp(ack, adr_ack[i]);
      bb_stop();
    end
    bb_start();
    bb_byte({8'h58, 1'b1}, ack);
    cmp(ack, 1'b0);
    bb_byte({8'h09, 1'b1}, ack);
    cmp(ack, 1'b0);
    bb_byte({8'h01, 1'b1}, ack);
    cmp(ack, 1'b0);
    bb_stop();
    repeat (20) @(posedge ref_clk_i);
    cmp(chan_b, 6'h01);
    summarize();
  end

endmodule : tb_backlight_smbus_slave_port
